// file: hdl/cmsr_pkg.sv
`default_nettype none
package cmsr_pkg;
   // ----------------------------------------
   // opcode fields
   // ----------------------------------------
   localparam logic [5:0] OPC_MOVE_FILE = 6'h14;
   localparam logic [5:0] OPC_SUB_BORROW = 6'h16;
   localparam logic [9:0] OPC_LOAD_PTR = 10'h3B8;
   localparam logic [3:0] OPC_LOAD_PTR_2ND = 4'hF;
   localparam logic [14:0] OPC_INT_RETURN = 15'h0008;
   localparam int OPC6_MSB = 15;
   localparam int OPC6_LSB = 10;
   localparam int DEST_BIT = 9;
   localparam int ACCESS_BIT = 8;
   localparam int SHADOW_BIT = 0;
   localparam int PTR_SEL_MSB = 5;
   localparam int PTR_SEL_LSB = 4;
   localparam logic [1:0] PTR_COUNT = 2'h3;
   // ----------------------------------------
   // addressing
   // ----------------------------------------
   localparam logic [7:0] INDEXED_LIMIT = 8'h5F;
   localparam logic [7:0] ACCESS_SFR_BASE = 8'h60;
   localparam logic [3:0] ACCESS_SFR_BANK = 4'hF;
   localparam logic [3:0] BANK_ZERO = 4'h0;
   // ----------------------------------------
   // status flag positions
   // ----------------------------------------
   localparam int FLAG_C = 0;
   localparam int FLAG_DC = 1;
   localparam int FLAG_Z = 2;
   localparam int FLAG_OV = 3;
   localparam int FLAG_N = 4;
   localparam logic [4:0] FLAGS_RESET = 5'h00;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [11:0] PTR_RESET = 12'h000;
   localparam logic [20:0] PC_RESET = 21'h000000;
   typedef enum logic [1:0] {
      CMSR_IDLE,
      CMSR_PTR_LOW,
      CMSR_RET_IDLE
   } cmsr_state_t;
endpackage : cmsr_pkg
`default_nettype wire

// file: hdl/cmsr_alu.sv
`timescale 1ns/100ps
`default_nettype none
// subtract with borrow: f - w - !c, flags N OV C DC Z
module cmsr_alu (
   input wire logic [7:0] f_i,
   input wire logic [7:0] w_i,
   input wire logic c_i,
   output logic [7:0] diff_o,
   output logic [4:0] flags_o
);
   logic [8:0] full;
   logic [4:0] low;
   always_comb begin
      full = {1'b0, f_i} + {1'b0, ~w_i} + {8'h00, c_i};
      low = {1'b0, f_i[3:0]} + {1'b0, ~w_i[3:0]} + {4'h0, c_i};
      diff_o = full[7:0];
      flags_o = 5'h00;
      flags_o[cmsr_pkg::FLAG_C] = full[8];
      flags_o[cmsr_pkg::FLAG_DC] = low[4];
      flags_o[cmsr_pkg::FLAG_Z] = (full[7:0] == cmsr_pkg::BYTE_ZERO);
      flags_o[cmsr_pkg::FLAG_N] = full[7];
      flags_o[cmsr_pkg::FLAG_OV] = (f_i[7] != w_i[7]) && (full[7] != f_i[7]);
   end
endmodule : cmsr_alu
`default_nettype wire

// file: hdl/cmsr_core.sv
// Notes on behaviour
// - move-file copies the file value to destination, touching only N and Z.
// - destination bit 0 writes the accumulator, 1 writes back to the file.
// - access bit 0 uses the access bank, 1 takes the bank from bank select.
// - extended set, access 0, address up to 95: indexed literal offset addressing.
// - subtract with borrow is f - w - !c, sets N OV C DC Z, one cycle.
// - load-pointer takes two words; high part first cycle, low byte second.
// - interrupt return pops stack top to pc, sets a global enable, idle second cycle.
// - shadow bit set restores accumulator, flags and bank select from shadows.
`timescale 1ns/100ps
`default_nettype none
module cmsr_core (
   input wire logic clk_sys_i,
   input wire logic srst_i,
   input wire logic instr_valid_i,
   input wire logic [15:0] instr_i,
   input wire logic ext_set_en_i,
   input wire logic high_priority_sel_i,
   input wire logic [7:0] file_rdata_i,
   input wire logic [11:0] index_base_i,
   input wire logic [20:0] stack_top_i,
   input wire logic [7:0] accumulator_shadow_i,
   input wire logic [4:0] flags_shadow_i,
   input wire logic [3:0] bank_select_shadow_i,
   input wire logic [3:0] bank_select_wdata_i,
   input wire logic bank_select_we_i,
   output logic [11:0] file_addr_o,
   output logic [7:0] file_wdata_o,
   output logic file_we_o,
   output logic [7:0] accumulator_o,
   output logic [4:0] flags_o,
   output logic [3:0] bank_select_reg_o,
   output logic [11:0] pointer0_o,
   output logic [11:0] pointer1_o,
   output logic [11:0] pointer2_o,
   output logic [20:0] pc_o,
   output logic stack_pop_o,
   output logic high_priority_global_enable_o,
   output logic low_priority_global_enable_o,
   output logic busy_o
);
   cmsr_pkg::cmsr_state_t state;
   logic [5:0] opc6;
   logic move_file_op;
   logic subtract_with_borrow_op;
   logic load_pointer_literal_op;
   logic interrupt_return_op;
   logic dest_file;
   logic [11:0] eff_addr;
   logic [7:0] sub_diff;
   logic [4:0] sub_flags;
   logic [1:0] ptr_sel;
   logic [3:0] ptr_high_lit;
   localparam int PTR_SEL_MSB_C = cmsr_pkg::PTR_SEL_MSB;
   logic [1:0] ptr_sel_now;
   logic go;

   // ----------------------------------------
   // decode
   // ----------------------------------------
   assign go = instr_valid_i && (state == cmsr_pkg::CMSR_IDLE);
   assign opc6 = instr_i[cmsr_pkg::OPC6_MSB:cmsr_pkg::OPC6_LSB];
   assign move_file_op = go && (opc6 == cmsr_pkg::OPC_MOVE_FILE);
   assign subtract_with_borrow_op = go && (opc6 == cmsr_pkg::OPC_SUB_BORROW);
   assign load_pointer_literal_op = go && (instr_i[15:6] == cmsr_pkg::OPC_LOAD_PTR)
      && (instr_i[PTR_SEL_MSB_C:cmsr_pkg::PTR_SEL_LSB] < cmsr_pkg::PTR_COUNT);
   assign interrupt_return_op = go && (instr_i[15:1] == cmsr_pkg::OPC_INT_RETURN);
   assign dest_file = instr_i[cmsr_pkg::DEST_BIT];

   // access bank: below 0x60 is ram bank 0 (or indexed), from 0x60 up the special registers
   always_comb begin
      if (instr_i[cmsr_pkg::ACCESS_BIT]) begin
         eff_addr = {bank_select_reg_o, instr_i[7:0]};
      end else if (ext_set_en_i && (instr_i[7:0] <= cmsr_pkg::INDEXED_LIMIT)) begin
         eff_addr = index_base_i + {4'h0, instr_i[7:0]};
      end else if (instr_i[7:0] >= cmsr_pkg::ACCESS_SFR_BASE) begin
         eff_addr = {cmsr_pkg::ACCESS_SFR_BANK, instr_i[7:0]};
      end else begin
         eff_addr = {cmsr_pkg::BANK_ZERO, instr_i[7:0]};
      end
   end
   assign file_addr_o = eff_addr;

   cmsr_alu u_alu (
      .f_i(file_rdata_i),
      .w_i(accumulator_o),
      .c_i(flags_o[cmsr_pkg::FLAG_C]),
      .diff_o(sub_diff),
      .flags_o(sub_flags)
   );

   // ----------------------------------------
   // sequencing
   // ----------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         state <= cmsr_pkg::CMSR_IDLE;
         busy_o <= 1'b0;
      end else begin
         unique case (state)
            cmsr_pkg::CMSR_IDLE: begin
               if (load_pointer_literal_op) begin
                  state <= cmsr_pkg::CMSR_PTR_LOW;
                  busy_o <= 1'b1;
               end else if (interrupt_return_op) begin
                  state <= cmsr_pkg::CMSR_RET_IDLE;
                  busy_o <= 1'b1;
               end
            end
            cmsr_pkg::CMSR_PTR_LOW: begin
               if (instr_valid_i) begin
                  state <= cmsr_pkg::CMSR_IDLE;
                  busy_o <= 1'b0;
               end
            end
            cmsr_pkg::CMSR_RET_IDLE: begin
               state <= cmsr_pkg::CMSR_IDLE;
               busy_o <= 1'b0;
            end
            default: begin
               state <= cmsr_pkg::CMSR_IDLE;
               busy_o <= 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------
   // file write port
   // ----------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         file_we_o <= 1'b0;
         file_wdata_o <= cmsr_pkg::BYTE_ZERO;
      end else begin
         file_we_o <= (move_file_op || subtract_with_borrow_op) && dest_file;
         file_wdata_o <= move_file_op ? file_rdata_i : sub_diff;
      end
   end

   // ----------------------------------------
   // accumulator, flags, bank select
   // ----------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         accumulator_o <= cmsr_pkg::BYTE_ZERO;
         flags_o <= cmsr_pkg::FLAGS_RESET;
         bank_select_reg_o <= cmsr_pkg::BANK_ZERO;
      end else begin
         if (bank_select_we_i) begin
            bank_select_reg_o <= bank_select_wdata_i;
         end
         if (move_file_op) begin
            if (!dest_file) begin
               accumulator_o <= file_rdata_i;
            end
            flags_o[cmsr_pkg::FLAG_N] <= file_rdata_i[7];
            flags_o[cmsr_pkg::FLAG_Z] <= (file_rdata_i == cmsr_pkg::BYTE_ZERO);
         end else if (subtract_with_borrow_op) begin
            if (!dest_file) begin
               accumulator_o <= sub_diff;
            end
            flags_o <= sub_flags;
         end else if (interrupt_return_op && instr_i[cmsr_pkg::SHADOW_BIT]) begin
            accumulator_o <= accumulator_shadow_i;
            flags_o <= flags_shadow_i;
            bank_select_reg_o <= bank_select_shadow_i;
         end
      end
   end

   // ----------------------------------------
   // pointers: high nibble first, low byte on second word
   // ----------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         ptr_sel <= 2'h0;
      end else if (load_pointer_literal_op) begin
         // the selector must survive into the second word, which carries none
         ptr_sel <= ptr_sel_now;
      end
   end
   assign ptr_high_lit = instr_i[3:0];
   assign ptr_sel_now = instr_i[PTR_SEL_MSB_C:cmsr_pkg::PTR_SEL_LSB];
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         pointer0_o <= cmsr_pkg::PTR_RESET;
         pointer1_o <= cmsr_pkg::PTR_RESET;
         pointer2_o <= cmsr_pkg::PTR_RESET;
      end else begin
         if (load_pointer_literal_op && ptr_sel_now == 2'h0) pointer0_o[11:8] <= ptr_high_lit;
         if (load_pointer_literal_op && ptr_sel_now == 2'h1) pointer1_o[11:8] <= ptr_high_lit;
         if (load_pointer_literal_op && ptr_sel_now == 2'h2) pointer2_o[11:8] <= ptr_high_lit;
         if (state == cmsr_pkg::CMSR_PTR_LOW && instr_valid_i) begin
            if (ptr_sel == 2'h0) pointer0_o[7:0] <= instr_i[7:0];
            if (ptr_sel == 2'h1) pointer1_o[7:0] <= instr_i[7:0];
            if (ptr_sel == 2'h2) pointer2_o[7:0] <= instr_i[7:0];
         end
      end
   end

   // ----------------------------------------
   // interrupt return
   // ----------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         pc_o <= cmsr_pkg::PC_RESET;
         stack_pop_o <= 1'b0;
         high_priority_global_enable_o <= 1'b0;
         low_priority_global_enable_o <= 1'b0;
      end else begin
         stack_pop_o <= interrupt_return_op;
         if (interrupt_return_op) begin
            pc_o <= stack_top_i;
            if (high_priority_sel_i) begin
               high_priority_global_enable_o <= 1'b1;
            end else begin
               low_priority_global_enable_o <= 1'b1;
            end
         end
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   property p_move_flags;
      @(posedge clk_sys_i) disable iff (srst_i)
      move_file_op |=> flags_o[cmsr_pkg::FLAG_C] == $past(flags_o[cmsr_pkg::FLAG_C])
         && flags_o[cmsr_pkg::FLAG_OV] == $past(flags_o[cmsr_pkg::FLAG_OV]);
   endproperty
   a_move_flags: assert property (p_move_flags) else $error("move changed C or OV");
   property p_move_dest;
      @(posedge clk_sys_i) disable iff (srst_i)
      move_file_op && !dest_file |=> accumulator_o == $past(file_rdata_i) && !file_we_o;
   endproperty
   a_move_dest: assert property (p_move_dest) else $error("move to accumulator wrong");
   property p_file_dest;
      @(posedge clk_sys_i) disable iff (srst_i)
      (move_file_op || subtract_with_borrow_op) && dest_file |=> file_we_o;
   endproperty
   a_file_dest: assert property (p_file_dest) else $error("file write missing");
   property p_bank;
      @(posedge clk_sys_i) disable iff (srst_i)
      instr_i[cmsr_pkg::ACCESS_BIT] |-> file_addr_o[11:8] == bank_select_reg_o;
   endproperty
   a_bank: assert property (p_bank) else $error("bank select not used");
   property p_indexed;
      @(posedge clk_sys_i) disable iff (srst_i)
      ext_set_en_i && !instr_i[cmsr_pkg::ACCESS_BIT] && instr_i[7:0] <= cmsr_pkg::INDEXED_LIMIT
         |-> file_addr_o == index_base_i + {4'h0, instr_i[7:0]};
   endproperty
   a_indexed: assert property (p_indexed) else $error("indexed address wrong");
   property p_sub;
      @(posedge clk_sys_i) disable iff (srst_i)
      subtract_with_borrow_op && !dest_file |=> accumulator_o ==
         8'($past(file_rdata_i) - $past(accumulator_o) - {7'h00, !$past(flags_o[cmsr_pkg::FLAG_C])});
   endproperty
   a_sub: assert property (p_sub) else $error("subtract result wrong");
   property p_ptr;
      @(posedge clk_sys_i) disable iff (srst_i)
      load_pointer_literal_op |=> busy_o ##1 (!busy_o || !$past(instr_valid_i));
   endproperty
   a_ptr: assert property (p_ptr) else $error("pointer load length wrong");
   property p_ret;
      @(posedge clk_sys_i) disable iff (srst_i)
      interrupt_return_op |=> pc_o == $past(stack_top_i) && busy_o ##1 !busy_o;
   endproperty
   a_ret: assert property (p_ret) else $error("interrupt return wrong");
   property p_shadow;
      @(posedge clk_sys_i) disable iff (srst_i)
      interrupt_return_op && !instr_i[cmsr_pkg::SHADOW_BIT] && !bank_select_we_i
         |=> $stable(accumulator_o) && $stable(flags_o) && $stable(bank_select_reg_o);
   endproperty
   a_shadow: assert property (p_shadow) else $error("registers changed without shadow");
endmodule : cmsr_core
`default_nettype wire

// file: tb/cpu_move_sub_return_ops_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin \
   tests_run++; \
   if ((got) !== (exp)) begin \
      error_cnt++; \
      $display("wrong value t=%0t got %h exp %h", $time, got, exp); \
   end \
end
module cpu_move_sub_return_ops_tb;
   logic clk_sys_i, srst_i, instr_valid_i, ext_set_en_i, high_priority_sel_i, bank_select_we_i;
   logic [15:0] instr_i;
   logic [7:0] file_rdata_i, accumulator_shadow_i, file_wdata_o, accumulator_o;
   logic [11:0] index_base_i, file_addr_o, pointer0_o, pointer1_o, pointer2_o, addr_seen;
   logic [20:0] stack_top_i, pc_o;
   logic [4:0] flags_shadow_i, flags_o;
   logic [3:0] bank_select_shadow_i, bank_select_wdata_i, bank_select_reg_o;
   logic file_we_o, stack_pop_o, high_priority_global_enable_o, low_priority_global_enable_o, busy_o;
   logic [11:0] ptr_exp [3];
   logic [12:0] exp_sub;
   int error_cnt = 0;
   int tests_run = 0;
   // ----------------------------------------
   // case tables
   // ----------------------------------------
   logic ad_ext [6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
   logic ad_a [6] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
   logic [7:0] ad_f [6] = '{8'h12, 8'h5F, 8'h60, 8'h5F, 8'h60, 8'h10};
   logic [11:0] ad_exp [6] = '{12'h312, 12'h05F, 12'hF60, 12'h2FF, 12'hF60, 12'h310};
   logic [7:0] sb_f [4] = '{8'h19, 8'h1B, 8'h03, 8'h80};
   logic [7:0] sb_w [4] = '{8'h0D, 8'h1A, 8'h0E, 8'h01};
   logic sb_c [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
   logic sb_d [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

   cmsr_core uut (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .instr_valid_i(instr_valid_i), .instr_i(instr_i),
      .ext_set_en_i(ext_set_en_i), .high_priority_sel_i(high_priority_sel_i), .file_rdata_i(file_rdata_i),
      .index_base_i(index_base_i), .stack_top_i(stack_top_i), .accumulator_shadow_i(accumulator_shadow_i),
      .flags_shadow_i(flags_shadow_i), .bank_select_shadow_i(bank_select_shadow_i),
      .bank_select_wdata_i(bank_select_wdata_i), .bank_select_we_i(bank_select_we_i),
      .file_addr_o(file_addr_o), .file_wdata_o(file_wdata_o), .file_we_o(file_we_o),
      .accumulator_o(accumulator_o), .flags_o(flags_o), .bank_select_reg_o(bank_select_reg_o),
      .pointer0_o(pointer0_o), .pointer1_o(pointer1_o), .pointer2_o(pointer2_o), .pc_o(pc_o),
      .stack_pop_o(stack_pop_o), .high_priority_global_enable_o(high_priority_global_enable_o),
      .low_priority_global_enable_o(low_priority_global_enable_o), .busy_o(busy_o));

   // plain subtraction; carry and digit carry read as "no borrow taken"
   function automatic logic [12:0] sbb(input logic [7:0] f, input logic [7:0] w, input logic c);
      logic [8:0] full;
      logic [4:0] low;
      full = {1'b0, f} - {1'b0, w} - {8'h00, !c};
      low = {1'b0, f[3:0]} - {1'b0, w[3:0]} - {4'h0, !c};
      return {full[7], (f[7] != w[7]) && (full[7] != f[7]), full[7:0] == 8'h00, !low[4], !full[8], full[7:0]};
   endfunction : sbb

   task automatic tally_and_finish;
      $display("checks %0d errors %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : tally_and_finish

   // one-word instruction; returns in the cycle after the taken edge
   task automatic op(input logic [15:0] w, input logic [7:0] rd);
      @(posedge clk_sys_i);
      instr_valid_i <= 1'b1;
      instr_i <= w;
      file_rdata_i <= rd;
      @(negedge clk_sys_i);
      addr_seen = file_addr_o;
      @(posedge clk_sys_i);
      instr_valid_i <= 1'b0;
      @(negedge clk_sys_i);
   endtask : op

   task automatic chk_ptrs;
      `CHK(pointer0_o, ptr_exp[0])
      `CHK(pointer1_o, ptr_exp[1])
      `CHK(pointer2_o, ptr_exp[2])
   endtask : chk_ptrs

   // the low word follows at once, inside the busy cycle
   task automatic lptr(input logic [1:0] sel, input logic [11:0] k);
      @(posedge clk_sys_i);
      instr_valid_i <= 1'b1;
      instr_i <= {cmsr_pkg::OPC_LOAD_PTR, sel, k[11:8]};
      @(posedge clk_sys_i);
      instr_i <= {cmsr_pkg::OPC_LOAD_PTR_2ND, 4'h0, k[7:0]};
      if (sel != 2'h3) ptr_exp[sel][11:8] = k[11:8];
      @(negedge clk_sys_i);
      chk_ptrs();
      `CHK(busy_o, sel != 2'h3)
      @(posedge clk_sys_i);
      instr_valid_i <= 1'b0;
      if (sel != 2'h3) ptr_exp[sel] = k;
      @(negedge clk_sys_i);
      chk_ptrs();
      `CHK(busy_o, 1'b0)
   endtask : lptr

   // a move word offered in the idle cycle must be dropped
   task automatic ret(input logic s, input logic hp);
      @(posedge clk_sys_i);
      instr_valid_i <= 1'b1;
      instr_i <= {cmsr_pkg::OPC_INT_RETURN, s};
      high_priority_sel_i <= hp;
      @(posedge clk_sys_i);
      instr_i <= {cmsr_pkg::OPC_MOVE_FILE, 2'b01, 8'h01};
      file_rdata_i <= 8'hC3;
      @(negedge clk_sys_i);
      `CHK(pc_o, stack_top_i)
      `CHK(stack_pop_o, 1'b1)
      `CHK(busy_o, 1'b1)
      @(posedge clk_sys_i);
      instr_valid_i <= 1'b0;
      @(negedge clk_sys_i);
      `CHK(busy_o, 1'b0)
      `CHK(stack_pop_o, 1'b0)
      `CHK(hp ? high_priority_global_enable_o : low_priority_global_enable_o, 1'b1)
   endtask : ret

   initial begin
      clk_sys_i = 1'b0;
      forever #2.5 clk_sys_i = ~clk_sys_i;
   end

   initial begin
      repeat (5000) @(posedge clk_sys_i);
      error_cnt++;
      tally_and_finish();
   end

   initial begin
      {srst_i, instr_valid_i, ext_set_en_i, high_priority_sel_i, bank_select_we_i} = 5'h10;
      {instr_i, file_rdata_i, accumulator_shadow_i, flags_shadow_i, bank_select_shadow_i} = '0;
      bank_select_wdata_i = 4'h0;
      index_base_i = 12'h2A0;
      stack_top_i = 21'h01ABCD;
      ptr_exp = '{12'h000, 12'h000, 12'h000};
      repeat (4) @(posedge clk_sys_i);
      srst_i <= 1'b0;
      @(negedge clk_sys_i);
      `CHK({accumulator_o, flags_o, bank_select_reg_o, pc_o}, 38'h0)
      `CHK({busy_o, file_we_o, stack_pop_o, high_priority_global_enable_o, low_priority_global_enable_o}, 5'h0)
      chk_ptrs();
      @(posedge clk_sys_i);
      bank_select_wdata_i <= 4'h3;
      bank_select_we_i <= 1'b1;
      @(posedge clk_sys_i);
      bank_select_we_i <= 1'b0;
      @(negedge clk_sys_i);
      `CHK(bank_select_reg_o, 4'h3)
      for (int i = 0; i < 6; i++) begin
         @(posedge clk_sys_i);
         ext_set_en_i <= ad_ext[i];
         op({cmsr_pkg::OPC_MOVE_FILE, 1'b0, ad_a[i], ad_f[i]}, ad_f[i]);
         `CHK(addr_seen, ad_exp[i])
         `CHK(accumulator_o, ad_f[i])
      end
      // ----------------------------------------
      // shadow restore, move flags, pointers
      // ----------------------------------------
      @(posedge clk_sys_i);
      {accumulator_shadow_i, flags_shadow_i, bank_select_shadow_i} <= {8'h11, 5'h0B, 4'h3};
      ret(1'b1, 1'b1);
      `CHK({accumulator_o, flags_o, bank_select_reg_o}, {8'h11, 5'h0B, 4'h3})
      op({cmsr_pkg::OPC_MOVE_FILE, 2'b11, 8'h20}, 8'h00);
      `CHK({file_we_o, file_wdata_o, accumulator_o}, {1'b1, 8'h00, 8'h11})
      `CHK(flags_o, 5'h0F)
      @(negedge clk_sys_i);
      `CHK(file_we_o, 1'b0)
      op({cmsr_pkg::OPC_MOVE_FILE, 2'b01, 8'h20}, 8'h80);
      `CHK({file_we_o, accumulator_o, flags_o}, {1'b0, 8'h80, 5'h1B})
      for (int i = 0; i < 4; i++) lptr(i[1:0], 12'hA5C ^ {i[3:0], 8'h3E});
      lptr(2'h2, 12'hFFF);
      `CHK(flags_o, 5'h1B)
      @(posedge clk_sys_i);
      {accumulator_shadow_i, flags_shadow_i, bank_select_shadow_i, stack_top_i} <= {8'h99, 5'h15, 4'h7, 21'h000456};
      ret(1'b0, 1'b0);
      `CHK({accumulator_o, flags_o, bank_select_reg_o}, {8'h80, 5'h1B, 4'h3})
      `CHK(high_priority_global_enable_o, 1'b1)
      // ----------------------------------------
      // subtract with borrow
      // ----------------------------------------
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_sys_i);
         {accumulator_shadow_i, flags_shadow_i} <= {sb_w[i], 4'hA, sb_c[i]};
         ret(1'b1, i[0]);
         exp_sub = sbb(sb_f[i], sb_w[i], sb_c[i]);
         op({cmsr_pkg::OPC_SUB_BORROW, sb_d[i], 1'b1, 8'h30}, sb_f[i]);
         `CHK(flags_o, exp_sub[12:8])
         `CHK(file_we_o, sb_d[i])
         `CHK(accumulator_o, sb_d[i] ? sb_w[i] : exp_sub[7:0])
         if (sb_d[i]) `CHK(file_wdata_o, exp_sub[7:0])
      end
      tally_and_finish();
   end
endmodule : cpu_move_sub_return_ops_tb
`default_nettype wire
